/* pkg/tss_pkg.sv */
package tss_pkg;
    // frame geometry
    localparam int STREAMS = 8;
    localparam int CHANNELS = 32;
    localparam int ENTRIES = STREAMS * CHANNELS;
    localparam int BYTE_W = 8;

    // position counter {channel, bit, phase}
    localparam int CHAN_W = 5;
    localparam int BITCNT_W = 3;
    localparam int PHASE_W = 1;
    localparam int TICK_W = CHAN_W + BITCNT_W + PHASE_W;
    localparam logic [TICK_W-1:0] TICK_RESET = 9'h000;
    localparam logic [TICK_W-1:0] TICK_STEP = 9'h001;
    localparam logic [PHASE_W-1:0] PHASE_SAMPLE = 1'h0;
    localparam logic [PHASE_W-1:0] PHASE_LAST = 1'h1;
    localparam logic [BITCNT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [BITCNT_W-1:0] BIT_STEP = 3'h1;
    localparam logic [CHAN_W-1:0] CHAN_STEP = 5'h01;
    localparam logic [CHAN_W-1:0] CHAN_SKIP = 5'h02;

    // upper connection memory fields
    localparam int CMU_OE_BIT = 0;
    localparam int CMU_CCO_BIT = 1;
    localparam int CMU_PROC_BIT = 2;

    // host address: top bit picks memory space
    localparam int ADDR_MEM_BIT = 5;

    // values after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CMU_RESET = 8'h00;
    localparam logic [7:0] CML_RESET = 8'h00;
    localparam logic [7:0] DMEM_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    typedef enum logic [1:0] {MS_NONE, MS_DMEM, MS_CML, MS_CMH} tss_memsel_t;

    typedef struct packed {
        logic split;
        logic procAll;
        logic unused;
        tss_memsel_t memSel;
        logic [2:0] stream;
    } tss_ctrl_t;

    typedef struct packed {
        logic strobe;
        logic csN;
        logic rw;
        logic [5:0] addr;
        logic [7:0] data;
    } tss_host_pins_t;

    typedef struct packed {
        logic write;
        tss_memsel_t sel;
        logic [7:0] index;
        logic [7:0] data;
    } tss_mem_req_t;

    typedef struct packed {
        logic [2:0] stream;
        logic [4:0] chan;
    } tss_src_t;

    typedef enum logic [1:0] {H_IDLE, H_WAIT, H_ACK} tss_host_state_t;
endpackage

/* hdl/tss_sync2.sv */
`timescale 1ns/1ps
module tss_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    // plain two-stage synchroniser; stage1 feeds only dout
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

/* hdl/tss_switch_top.sv */
`timescale 1ns/1ps
// Behaviour
// R1: ack pulled low when host access done
// R2: eight inputs, 32 channels, 2.048 Mb/s
// R3: timing source supplies frame pulse
// R4: timing source supplies 4.096 MHz clock
// R5: access only with strobe high, select low
// R6: read/write level sets data bus direction
// R7: memories and control reached only when selected
// R8: eight three-state outputs, 32 channels each
// R9: gate low floats all outputs
// R10: control output sends 256 bits per frame
// R11: connection entry is two 8-bit halves
// R12: one connection entry per output channel
// R13: processor mode sends lower entry byte
// R14: connection mode sends addressed data byte
// R15: fetch byte during preceding channel slot
// R16: processor byte repeats every frame
// R17: upper entry: mode, driver enable, control bit
// R18: same-slot switching appears next frame
// R19: adjacent-slot switching waits one frame
// R20: fastest delay depends on stream pairing
// R21: bit2 processor, bit0 enable, bit1 control
// R22: control bit leads its channel by one
// R23: fast pairs follow the stream table
// R24: address top bit picks register or channel
// R25: every input byte stored each frame
// R26: each bit spans two clock periods
module tss_switch_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic host_strobe,
    input wire logic host_cs_n,
    input wire logic host_rw,
    input wire logic [5:0] host_addr,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    output logic transfer_ack_n,
    output logic transfer_ack_oe,
    input wire logic bit_clock_4m,
    input wire logic frame_sync_n,
    input wire logic [7:0] serial_in_streams,
    input wire logic output_drive_gate,
    output logic [7:0] serial_out_streams,
    output logic [7:0] serial_out_oe,
    output logic control_channel_out
);
    // host side, mclk domain
    tss_pkg::tss_host_pins_t pinsRaw;
    tss_pkg::tss_host_pins_t pins;
    tss_pkg::tss_host_state_t hostState;
    tss_pkg::tss_ctrl_t ctrl;
    tss_pkg::tss_mem_req_t req;
    tss_pkg::tss_memsel_t target;
    logic hostActive;
    logic hostStart;
    logic memSlow;
    logic reqTgl;
    logic ackSync;
    logic reqDone;
    logic [7:0] linkRdData;

    // all host pins are asynchronous to mclk
    assign pinsRaw = {host_strobe, host_cs_n, host_rw, host_addr, host_data_in};

    tss_sync2 #(
        .WIDTH($bits(tss_pkg::tss_host_pins_t))
    ) u_host_sync (
        .clk(mclk),
        .rst(rst),
        .din(pinsRaw),
        .dout(pins)
    );

    // an access exists only while strobe is high and select is low
    assign hostActive = pins.strobe && !pins.csN; // [R5] [R7]
    assign hostStart = (hostState == tss_pkg::H_IDLE) && hostActive;
    assign reqDone = (ackSync == reqTgl);

    // split mode forces reads to data memory and writes to the lower half
    always_comb begin
        target = ctrl.memSel;
        if (ctrl.split) begin
            target = pins.rw ? tss_pkg::MS_DMEM : tss_pkg::MS_CML;
        end
    end

    // data memory is read-only from the host; unused select never goes out
    assign memSlow = (target == tss_pkg::MS_CML) || (target == tss_pkg::MS_CMH)
                     || ((target == tss_pkg::MS_DMEM) && pins.rw);

    // host access sequencer
    always_ff @(posedge mclk) begin
        if (rst) begin
            hostState <= tss_pkg::H_IDLE;
        end else begin
            case (hostState)
                tss_pkg::H_IDLE: begin
                    if (hostActive) begin
                        if (pins.addr[tss_pkg::ADDR_MEM_BIT] && memSlow) begin // [R24]
                            hostState <= tss_pkg::H_WAIT;
                        end else begin
                            hostState <= tss_pkg::H_ACK;
                        end
                    end
                end
                tss_pkg::H_WAIT: begin
                    if (reqDone) begin
                        hostState <= tss_pkg::H_ACK;
                    end
                end
                tss_pkg::H_ACK: begin
                    // hold the ack until the host lets go of the strobe or the select
                    if (!hostActive) begin
                        hostState <= tss_pkg::H_IDLE;
                    end
                end
                default: begin
                    hostState <= tss_pkg::H_IDLE;
                end
            endcase
        end
    end

    // control register: any address with the top bit low
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl <= tss_pkg::tss_ctrl_t'(tss_pkg::CTRL_RESET);
        end else if (hostStart && !pins.addr[tss_pkg::ADDR_MEM_BIT] && !pins.rw) begin // [R24] [R6]
            ctrl <= tss_pkg::tss_ctrl_t'(pins.data);
        end
    end

    // memory request toward the link domain; fields stay put until the next toggle
    always_ff @(posedge mclk) begin
        if (rst) begin
            req <= '0;
            reqTgl <= 1'b0;
        end else if (hostStart && pins.addr[tss_pkg::ADDR_MEM_BIT] && memSlow) begin // [R24]
            req.write <= !pins.rw; // [R6]
            req.sel <= target;
            req.index <= {ctrl.stream, pins.addr[4:0]};
            req.data <= pins.data;
            reqTgl <= ~reqTgl;
        end
    end

    // read data for the host bus
    always_ff @(posedge mclk) begin
        if (rst) begin
            host_data_out <= tss_pkg::READ_IDLE;
        end else if (hostStart && pins.rw) begin
            if (!pins.addr[tss_pkg::ADDR_MEM_BIT]) begin
                host_data_out <= ctrl;
            end else begin
                host_data_out <= tss_pkg::READ_IDLE;
            end
        end else if ((hostState == tss_pkg::H_WAIT) && reqDone && !req.write) begin
            // linkRdData is stable here: the link side only changes it on a new request
            host_data_out <= linkRdData;
        end
    end

    // bus drivers: ack is open drain, data driven only on reads
    always_ff @(posedge mclk) begin
        if (rst) begin
            transfer_ack_n <= 1'b1;
            transfer_ack_oe <= 1'b0;
            host_data_oe <= 1'b0;
        end else begin
            transfer_ack_n <= !((hostState == tss_pkg::H_ACK) && hostActive); // [R1]
            transfer_ack_oe <= (hostState == tss_pkg::H_ACK) && hostActive; // [R1]
            host_data_oe <= (hostState == tss_pkg::H_ACK) && hostActive && pins.rw; // [R6]
        end
    end

    // link side, bit clock domain
    logic linkRst;
    logic [2:0] lvlRaw;
    logic [2:0] lvl;
    logic odeSync;
    logic peSync;
    logic reqSync;
    logic reqSeen;
    logic reqNew;
    logic [tss_pkg::TICK_W-1:0] tick;
    logic [4:0] chan;
    logic [2:0] bitCnt;
    logic phase;
    logic chanEnd;
    logic [4:0] next_chan;
    logic [2:0] next_bit;
    logic [4:0] ccoChan;
    logic [4:0] holdChan;
    logic holdValid;
    logic [7:0] dataMem [tss_pkg::ENTRIES];
    logic [7:0] cmUpper [tss_pkg::ENTRIES];
    logic [7:0] cmLower [tss_pkg::ENTRIES];
    logic [7:0] rxShift [tss_pkg::STREAMS];
    logic [7:0] rxHold [tss_pkg::STREAMS];

    // reset is released into the link domain two bit clocks late
    tss_sync2 u_rst_sync (
        .clk(bit_clock_4m),
        .rst(1'b0),
        .din(rst),
        .dout(linkRst)
    );

    // gate pin, global processor bit and request toggle are levels
    assign lvlRaw = {output_drive_gate, ctrl.procAll, reqTgl};

    tss_sync2 #(
        .WIDTH(3)
    ) u_link_sync (
        .clk(bit_clock_4m),
        .rst(linkRst),
        .din(lvlRaw),
        .dout(lvl)
    );

    assign odeSync = lvl[2];
    assign peSync = lvl[1];
    assign reqSync = lvl[0];
    assign reqNew = (reqSync != reqSeen);

    // position within the frame: two clocks per bit, eight bits per channel
    assign {chan, bitCnt, phase} = tick; // [R26] [R2]
    assign chanEnd = (bitCnt == tss_pkg::BIT_LAST) && (phase == tss_pkg::PHASE_LAST);
    assign next_chan = chan + tss_pkg::CHAN_STEP;

    // the frame pulse realigns the counter; a late pulse simply restarts the frame
    always_ff @(posedge bit_clock_4m) begin
        if (linkRst) begin
            tick <= tss_pkg::TICK_RESET;
        end else if (!frame_sync_n) begin // [R3] [R26]
            tick <= tss_pkg::TICK_RESET;
        end else begin
            tick <= tick + tss_pkg::TICK_STEP; // [R4]
        end
    end

    // receive: sample mid-bit, msb first, hold the byte for one channel
    always_ff @(posedge bit_clock_4m) begin
        if (linkRst) begin
            for (int s = 0; s < tss_pkg::STREAMS; s++) begin
                rxShift[s] <= tss_pkg::DMEM_RESET;
                rxHold[s] <= tss_pkg::DMEM_RESET;
            end
            holdChan <= '0;
            holdValid <= 1'b0;
        end else begin
            for (int s = 0; s < tss_pkg::STREAMS; s++) begin
                if (phase == tss_pkg::PHASE_SAMPLE) begin
                    rxShift[s] <= {rxShift[s][6:0], serial_in_streams[s]}; // [R2]
                end
                if (chanEnd) begin
                    rxHold[s] <= rxShift[s];
                end
            end
            if (chanEnd) begin
                holdChan <= chan;
                holdValid <= 1'b1;
            end
        end
    end

    // data memory: the held byte lands one channel after it arrived,
    // which is what makes same-slot and adjacent-slot switching slip a frame
    always_ff @(posedge bit_clock_4m) begin
        if (linkRst) begin
            for (int e = 0; e < tss_pkg::ENTRIES; e++) begin
                dataMem[e] <= tss_pkg::DMEM_RESET;
            end
        end else if (chanEnd && holdValid) begin
            for (int s = 0; s < tss_pkg::STREAMS; s++) begin
                dataMem[{3'(s), holdChan}] <= rxHold[s]; // [R25] [R18]
            end
        end
    end

    // connection memory, written only by host requests
    always_ff @(posedge bit_clock_4m) begin
        if (linkRst) begin
            for (int e = 0; e < tss_pkg::ENTRIES; e++) begin
                cmUpper[e] <= tss_pkg::CMU_RESET;
                cmLower[e] <= tss_pkg::CML_RESET;
            end
        end else if (reqNew && req.write) begin
            if (req.sel == tss_pkg::MS_CML) begin
                cmLower[req.index] <= req.data; // [R11] [R16]
            end else if (req.sel == tss_pkg::MS_CMH) begin
                cmUpper[req.index] <= req.data; // [R11] [R17]
            end
        end
    end

    // request handshake: reqSeen doubles as the acknowledge toggle
    always_ff @(posedge bit_clock_4m) begin
        if (linkRst) begin
            reqSeen <= 1'b0;
            linkRdData <= tss_pkg::READ_IDLE;
        end else if (reqNew) begin
            reqSeen <= reqSync;
            if (!req.write) begin
                case (req.sel)
                    tss_pkg::MS_DMEM: linkRdData <= dataMem[req.index];
                    tss_pkg::MS_CML: linkRdData <= cmLower[req.index];
                    tss_pkg::MS_CMH: linkRdData <= cmUpper[req.index];
                    default: linkRdData <= tss_pkg::READ_IDLE;
                endcase
            end
        end
    end

    tss_sync2 u_ack_sync (
        .clk(mclk),
        .rst(rst),
        .din(reqSeen),
        .dout(ackSync)
    );

    // transmit: one serialiser per output stream
    genvar o;
    generate
        for (o = 0; o < tss_pkg::STREAMS; o++) begin : g_tx
            logic [7:0] upper;
            logic [7:0] lower;
            logic [7:0] fetched;
            logic [7:0] txShift;
            logic procMode;
            logic chanOn;
            logic allowFast;
            logic enLoaded;
            logic serOe;
            tss_pkg::tss_src_t src;

            // look up the entry of the next channel of this stream
            always_comb begin
                upper = cmUpper[{3'(o), next_chan}]; // [R12] [R15]
                lower = cmLower[{3'(o), next_chan}];
                src = tss_pkg::tss_src_t'(lower);
                procMode = upper[tss_pkg::CMU_PROC_BIT] | peSync; // [R21] [R17]
                chanOn = upper[tss_pkg::CMU_OE_BIT] | peSync; // [R21]
                // stored-then-queued order: input s reaches outputs above 2*(s mod 4)
                allowFast = 3'(o) > {src.stream[1:0], 1'b0}; // [R20] [R23]
                if (procMode) begin
                    fetched = lower; // [R13] [R16]
                end else if (holdValid && (src.chan == holdChan) && allowFast) begin
                    fetched = rxHold[src.stream]; // [R23]
                end else begin
                    fetched = dataMem[src]; // [R14] [R19]
                end
            end

            // load at the channel boundary, shift at each bit boundary
            always_ff @(posedge bit_clock_4m) begin
                if (linkRst) begin
                    txShift <= tss_pkg::CML_RESET;
                    enLoaded <= 1'b0;
                    serOe <= 1'b0;
                end else if (chanEnd) begin
                    txShift <= fetched; // [R15]
                    enLoaded <= chanOn;
                    serOe <= chanOn && odeSync; // [R9]
                end else begin
                    if (phase == tss_pkg::PHASE_LAST) begin
                        txShift <= {txShift[6:0], 1'b0}; // [R8] [R26]
                    end
                    serOe <= enLoaded && odeSync; // [R9]
                end
            end

            assign serial_out_streams[o] = txShift[tss_pkg::BYTE_W-1];
            assign serial_out_oe[o] = serOe;
        end
    endgenerate

    // control output: bit b of channel c carries stream b of channel c+1
    always_comb begin
        next_bit = bitCnt + tss_pkg::BIT_STEP;
        ccoChan = (bitCnt == tss_pkg::BIT_LAST) ? chan + tss_pkg::CHAN_SKIP : chan + tss_pkg::CHAN_STEP; // [R22]
    end

    // 8 streams x 32 channels gives 256 bits per frame, one per bit slot
    always_ff @(posedge bit_clock_4m) begin
        if (linkRst) begin
            control_channel_out <= 1'b0;
        end else if (phase == tss_pkg::PHASE_LAST) begin
            control_channel_out <= cmUpper[{next_bit, ccoChan}][tss_pkg::CMU_CCO_BIT]; // [R10] [R21] [R22]
        end
    end
endmodule

/* sim/tss_switch_assertions.sv */
`timescale 1ns/1ps
// host handshake on mclk, serial timing on the bit clock
module tss_switch_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire logic host_strobe,
    input wire logic host_cs_n,
    input wire logic host_rw,
    input wire logic [5:0] host_addr,
    input wire logic [7:0] host_data_in,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe,
    input wire logic transfer_ack_n,
    input wire logic transfer_ack_oe,
    input wire logic bit_clock_4m,
    input wire logic frame_sync_n,
    input wire logic [7:0] serial_in_streams,
    input wire logic output_drive_gate,
    input wire logic [7:0] serial_out_streams,
    input wire logic [7:0] serial_out_oe,
    input wire logic control_channel_out
);
    logic [8:0] hpos;
    logic aligned;

    // tick rebuilt from the frame pulse; bit-timing checks wait for the first pulse
    always_ff @(posedge bit_clock_4m) begin
        if (rst) begin
            hpos <= 9'h000;
            aligned <= 1'b0;
        end else if (!frame_sync_n) begin
            hpos <= 9'h000;
            aligned <= 1'b1;
        end else begin
            hpos <= hpos + 9'h001;
        end
    end

    property p_ack_level;
        @(posedge mclk) disable iff (rst) transfer_ack_n == !transfer_ack_oe;
    endproperty
    a_ack_level: assert property (p_ack_level) else $error("ack level disagrees with its enable");

    property p_ack_needs_select;
        @(posedge mclk) disable iff (rst) $rose(transfer_ack_oe) |-> host_strobe && !host_cs_n;
    endproperty
    a_ack_needs_select: assert property (p_ack_needs_select) else $error("ack without strobe and select");

    property p_ack_drops;
        @(posedge mclk) disable iff (rst) transfer_ack_oe && (host_cs_n || !host_strobe) |-> ##[1:8] !transfer_ack_oe;
    endproperty
    a_ack_drops: assert property (p_ack_drops) else $error("ack held after release");

    property p_ctrl_fast;
        @(posedge mclk) disable iff (rst)
            $rose(host_strobe) && !host_cs_n && !host_addr[5] |-> ##[1:8] transfer_ack_oe;
    endproperty
    a_ctrl_fast: assert property (p_ctrl_fast) else $error("control access not acked in time");

    property p_read_drives_bus;
        @(posedge mclk) disable iff (rst) host_data_oe |-> host_rw && transfer_ack_oe;
    endproperty
    a_read_drives_bus: assert property (p_read_drives_bus) else $error("data bus driven outside a read");

    property p_gate_floats;
        @(posedge bit_clock_4m) disable iff (rst) !output_drive_gate [*4] |-> serial_out_oe == 8'h00;
    endproperty
    a_gate_floats: assert property (p_gate_floats) else $error("stream driven with gate low");

    property p_bit_two_clocks;
        @(posedge bit_clock_4m) disable iff (rst || !aligned) $changed(serial_out_streams) |-> hpos[0] == 1'b0;
    endproperty
    a_bit_two_clocks: assert property (p_bit_two_clocks) else $error("stream bit changed mid-bit");

    property p_cco_two_clocks;
        @(posedge bit_clock_4m) disable iff (rst || !aligned) $changed(control_channel_out) |-> hpos[0] == 1'b0;
    endproperty
    a_cco_two_clocks: assert property (p_cco_two_clocks) else $error("control bit changed mid-bit");

    c_read: cover property (@(posedge mclk) disable iff (rst) host_data_oe);
    c_write: cover property (@(posedge mclk) disable iff (rst) transfer_ack_oe && !host_rw);
    c_float: cover property (@(posedge bit_clock_4m) disable iff (rst) $fell(|serial_out_oe));
endmodule

bind tss_switch_top tss_switch_assertions u_chk (.*);

/* sim/tss_far_model.sv */
`timescale 1ns/1ps
// backplane side: frame pulse, input streams, and a receiver for outputs
module tss_far_model (
    input wire logic bit_clock_4m,
    input wire logic [7:0] fill,
    input wire logic [7:0] serial_out_streams,
    input wire logic [7:0] serial_out_oe,
    input wire logic control_channel_out,
    output logic frame_sync_n,
    output logic [7:0] serial_in_streams,
    output logic [7:0][31:0][7:0] rxByte,
    output logic [7:0][31:0][7:0] rxOe,
    output logic [255:0] ccoBits,
    output int frames
);
    logic [8:0] pos = 9'h1f0;
    logic [8:0] nextPos;
    logic [7:0] b;

    initial begin
        frame_sync_n = 1'b1;
        serial_in_streams = 8'h00;
        rxByte = '0;
        rxOe = '0;
        ccoBits = '0;
        frames = 0;
    end

    assign nextPos = pos + 9'h001; // 512 clocks a frame, wraps by width

    // pulse one clock wide just ahead of tick 0
    always @(posedge bit_clock_4m) begin
        pos <= nextPos;
        frame_sync_n <= (nextPos != 9'h1ff);
        if (pos == 9'h1ff) begin
            frames <= frames + 1;
        end
        // each stream sends {stream, channel} xor fill, msb first, two clocks a bit
        for (int s = 0; s < 8; s++) begin
            b = {3'(s), nextPos[8:4]} ^ fill;
            serial_in_streams[s] <= b[~nextPos[3:1]];
        end
        // sample mid-bit, like a real receiver, so launch-edge skew cannot fool us
        if (pos[0] == 1'b0) begin
            for (int s = 0; s < 8; s++) begin
                rxByte[s][pos[8:4]][~pos[3:1]] <= serial_out_streams[s];
                rxOe[s][pos[8:4]][~pos[3:1]] <= serial_out_oe[s];
            end
            ccoBits[{pos[8:4], pos[3:1]}] <= control_channel_out;
        end
    end
endmodule

/* sim/tss_switch_test.sv */
`timescale 1ns/1ps
`define CHECK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            errTotal++; \
            $display("unexpected at %0t ns: got %0h expected %0h", $time, (got), (exp)); \
        end \
    end

module tss_switch_test;
    typedef struct packed {
        logic [2:0] s;
        logic [4:0] c;
        logic [7:0] up;
        logic [7:0] low;
        logic [7:0] expByte;
        logic [7:0] expOe;
    } tss_row_t;

    logic mclk = 1'b0;
    logic bit_clock_4m = 1'b0;
    logic rst = 1'b1;
    logic host_strobe = 1'b0;
    logic host_cs_n = 1'b1;
    logic host_rw = 1'b0;
    logic [5:0] host_addr = 6'h00;
    logic [7:0] host_data_in = 8'h00;
    logic output_drive_gate = 1'b1;
    logic [7:0] fill = 8'h5a;
    logic [7:0] host_data_out, serial_in_streams, serial_out_streams, serial_out_oe, rdVal;
    logic host_data_oe, transfer_ack_n, transfer_ack_oe, frame_sync_n, control_channel_out, ackWire;
    logic [7:0][31:0][7:0] rxByte, rxOe;
    logic [255:0] ccoBits;
    int frames;
    int errTotal = 0;
    int comparisons = 0;
    // stream, channel, upper, lower, byte seen, enables seen
    tss_row_t rows [5] = '{'{3'h0, 5'h00, 8'h05, 8'ha5, 8'ha5, 8'hff}, '{3'h7, 5'h1f, 8'h01, 8'h49, 8'h13, 8'hff},
        '{3'h3, 5'h05, 8'h01, 8'h49, 8'h13, 8'hff}, '{3'h5, 5'h02, 8'h04, 8'h77, 8'h00, 8'h00},
        '{3'h1, 5'h11, 8'h07, 8'h3c, 8'h3c, 8'hff}};

    assign ackWire = transfer_ack_oe ? transfer_ack_n : 1'b1; // pull-up holds the released line high

    initial begin
        forever #10 mclk = ~mclk;
    end
    // link clock, phase offset from mclk on purpose
    initial begin
        #1.7;
        forever #3 bit_clock_4m = ~bit_clock_4m;
    end

    tss_switch_top u_dut (.*);
    tss_far_model u_far (.*);

    task automatic closeOut();
        $display("comparisons %0d, mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hold until ack low, take data there, release
    task automatic hostOp(input logic rw, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge mclk);
        host_strobe <= 1'b1;
        host_cs_n <= 1'b0;
        host_rw <= rw;
        host_addr <= a;
        host_data_in <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ackWire !== 1'b0 && n < 300);
        q = host_data_out;
        if (n >= 300) errTotal++;
        host_strobe <= 1'b0;
        host_cs_n <= 1'b1;
        host_data_in <= ~d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (transfer_ack_oe !== 1'b0 && n < 20);
        repeat (2) @(posedge mclk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        hostOp(1'b0, a, d, q);
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] q);
        hostOp(1'b1, a, 8'h00, q);
    endtask

    task automatic waitFrames(input int k);
        int f0;
        int n;
        f0 = frames;
        n = 0;
        while (frames < f0 + k && n < 2000 * k) begin
            @(posedge mclk);
            n++;
        end
    endtask

    // half a select must never start a transfer
    task automatic noAck(input logic stb, input logic csn);
        int lows;
        lows = 0;
        @(posedge mclk);
        host_strobe <= stb;
        host_cs_n <= csn;
        repeat (30) begin
            @(posedge mclk);
            if (ackWire === 1'b0) lows++;
        end
        host_strobe <= 1'b0;
        host_cs_n <= 1'b1;
        `CHECK(lows, 0)
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        `CHECK({transfer_ack_n, transfer_ack_oe, host_data_oe}, 3'b100)
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        wr(6'h00, 8'h3a);
        rd(6'h1f, rdVal);
        `CHECK(rdVal, 8'h3a)
        // program every row, reading the upper half back
        for (int i = 0; i < 5; i++) begin
            wr(6'h00, {5'b00011, rows[i].s});
            wr({1'b1, rows[i].c}, rows[i].up);
            rd({1'b1, rows[i].c}, rdVal);
            `CHECK(rdVal, rows[i].up)
            wr(6'h00, {5'b00010, rows[i].s});
            wr({1'b1, rows[i].c}, rows[i].low);
        end
        waitFrames(3);
        for (int i = 0; i < 5; i++) begin
            `CHECK(rxOe[rows[i].s][rows[i].c], rows[i].expOe)
            if (rows[i].expOe != 8'h00) begin
                `CHECK(rxByte[rows[i].s][rows[i].c], rows[i].expByte)
            end
        end
        `CHECK(ccoBits, 256'h1 << 129)
        // data memory reads, write refused, empty memory select reads zero
        wr(6'h00, 8'h0a);
        rd(6'h29, rdVal);
        `CHECK(rdVal, 8'h13)
        wr(6'h29, 8'hff);
        rd(6'h29, rdVal);
        `CHECK(rdVal, 8'h13)
        wr(6'h00, 8'h02);
        rd(6'h29, rdVal);
        `CHECK(rdVal, 8'h00)
        // new input content reaches connected outputs
        fill <= 8'hc3;
        waitFrames(3);
        wr(6'h00, 8'h0a);
        rd(6'h29, rdVal);
        `CHECK(rdVal, 8'h8a)
        `CHECK(rxByte[7][31], 8'h8a)
        `CHECK(rxByte[3][5], 8'h8a)
        `CHECK(rxByte[0][0], 8'ha5)
        // split mode with the select on data memory: reads come from data memory
        wr(6'h00, 8'h8a);
        rd(6'h29, rdVal);
        `CHECK(rdVal, 8'h8a)
        // processor-all forces enable on a processor-mode row left off
        wr(6'h00, 8'h45);
        waitFrames(2);
        `CHECK(rxOe[5][2], 8'hff)
        `CHECK(rxByte[5][2], 8'h77)
        noAck(1'b1, 1'b1);
        noAck(1'b0, 1'b0);
        output_drive_gate <= 1'b0;
        waitFrames(2);
        `CHECK(|rxOe, 1'b0)
        output_drive_gate <= 1'b1;
        waitFrames(2);
        `CHECK(rxOe[0][0], 8'hff)
        // mid-run reset clears control and connection memory
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(6'h00, rdVal);
        `CHECK(rdVal, 8'h00)
        waitFrames(2);
        `CHECK(rxOe[0][0], 8'h00)
        closeOut();
    end

    // ample margin over the run
    initial begin
        repeat (60000) @(posedge mclk);
        errTotal++;
        closeOut();
    end
endmodule
